// file: hdl/dspr_fifo.sv
`timescale 1ns/1ps
module dspr_fifo
#(
  parameter int W = 8,
  parameter int D = 32
)
(
  input  wire logic         clk,       // system clock
  input  wire logic         rst_n,     // async reset, active low
  input  wire logic         in_valid,  // write request
  output logic              in_ready,  // space available
  input  wire logic [W-1:0] in_data,   // write data
  output logic              out_valid, // data available
  input  wire logic         out_ready, // read acknowledge
  output logic [W-1:0]      out_data   // head of queue
);
  localparam int AW = (D > 1) ? $clog2(D) : 1;

  logic [W-1:0]  mem_q [D];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0]   cnt_q;
  logic          push;
  logic          pop;

  assign in_ready  = (cnt_q != (AW+1)'(D));
  assign out_valid = (cnt_q != '0);
  assign out_data  = mem_q[rd_q];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_ff @(posedge clk)
  begin
    if (push)
      mem_q[wr_q] <= in_data;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end
    else
    begin
      if (push)
        wr_q <= (wr_q == AW'(D - 1)) ? '0 : wr_q + AW'(1);
      if (pop)
        rd_q <= (rd_q == AW'(D - 1)) ? '0 : rd_q + AW'(1);
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

// file: hdl/dspr_pkg.sv
package dspr_pkg;

  typedef enum logic [1:0] {DSPR_M_WAIT, DSPR_M_KEEP, DSPR_M_NORMAL} dspr_mode_t;

  typedef enum logic [2:0] {
    DSPR_RX_IDLE, DSPR_RX_START, DSPR_RX_DATA, DSPR_RX_PAR, DSPR_RX_STOP
  } dspr_rx_t;

  typedef enum logic [2:0] {
    DSPR_TX_IDLE, DSPR_TX_START, DSPR_TX_DATA, DSPR_TX_PAR, DSPR_TX_STOP
  } dspr_tx_t;

endpackage

// file: hdl/dspr_regs.svh
`ifndef DSPR_REGS_SVH
`define DSPR_REGS_SVH

// clock and timing
`define DSPR_SYS_CLK_HZ   20000000
`define DSPR_OS_RATE      16
`define DSPR_BAUD_BASE    1200
`define DSPR_REC_TIME_S   3
`define DSPR_GAP_BITS     6'd20

// register byte offsets
`define DSPR_OFF_CTRL     8'h00
`define DSPR_OFF_STATUS   8'h04
`define DSPR_OFF_TXDATA   8'h08
`define DSPR_OFF_RXDATA   8'h0c

// control register fields and reset value
`define DSPR_CTRL_BAUD    2:0
`define DSPR_CTRL_DATA8   3
`define DSPR_CTRL_PAR     5:4
`define DSPR_CTRL_ADDR    15:8
`define DSPR_CTRL_RST     16'h000d

// status register fields
`define DSPR_ST_MODE      1:0
`define DSPR_ST_ADDRD     2
`define DSPR_ST_PERR      3
`define DSPR_ST_FERR      4
`define DSPR_ST_OVR       5
`define DSPR_ST_RXV       6
`define DSPR_ST_TXFULL    7
`define DSPR_ST_TXBUSY    8

// field encodings
`define DSPR_BAUD_9600    3'd3
`define DSPR_BAUD_38400   3'd5
`define DSPR_PAR_NONE     2'd0
`define DSPR_PAR_ODD      2'd1
`define DSPR_PAR_EVEN     2'd2
`define DSPR_REC_ADDR     8'hfe

`endif

// file: hdl/dspr_serial_port.sv
// Overview of operation
// - Characters travel as idle-high NRZ frames: start bit, data bits, optional parity, stop.
// - Baud rate is selectable among 1200, 2400, 4800, 9600, 19200 and 38400 in both directions.
// - Seven or eight data bits per character are selectable and used in both directions.
// - Parity is odd, even or off; the transmitter makes the bit and the receiver checks it.
// - Out of reset the normal setup is 38400 baud, 8 data bits, no parity, one stop, address 0.
// - Receive and transmit use separate lines and can run at once, but transmit waits for an address match on receive.
// - For three seconds after reset the port listens at 9600 8N1 and answers address 254.
// - A message taken in that window makes the recovery setup stick until the next reset.
// - With no message in the window the port switches to the normal configured setup.
`timescale 1ns/1ps
`include "dspr_regs.svh"
module dspr_serial_port
#(
  parameter int unsigned REC_CYCLES = `DSPR_REC_TIME_S * `DSPR_SYS_CLK_HZ,
  parameter int          FIFO_DEPTH = 32
)
(
  input  wire logic        sys_clk,   // 20 MHz system clock
  input  wire logic        rst_n,     // async reset, active low
  input  wire logic        hsel,      // ahb slave select
  input  wire logic [31:0] haddr,     // ahb address
  input  wire logic [1:0]  htrans,    // ahb transfer type
  input  wire logic        hwrite,    // ahb write
  input  wire logic [2:0]  hsize,     // ahb size, word only
  input  wire logic [31:0] hwdata,    // ahb write data
  input  wire logic        hready,    // ahb bus ready
  output logic             hreadyout, // ahb slave ready
  output logic             hresp,     // ahb response, always okay
  output logic [31:0]      hrdata,    // ahb read data
  input  wire logic        ser_rx,    // host-to-drive serial line
  output logic             ser_tx     // drive-to-host serial line
);
  import dspr_pkg::*;

  function automatic logic [10:0] baud_div(input logic [2:0] sel);
    case (sel)
      3'd0:    baud_div = 11'(`DSPR_SYS_CLK_HZ / (`DSPR_OS_RATE * `DSPR_BAUD_BASE));
      3'd1:    baud_div = 11'(`DSPR_SYS_CLK_HZ / (`DSPR_OS_RATE * `DSPR_BAUD_BASE * 2));
      3'd2:    baud_div = 11'(`DSPR_SYS_CLK_HZ / (`DSPR_OS_RATE * `DSPR_BAUD_BASE * 4));
      3'd3:    baud_div = 11'(`DSPR_SYS_CLK_HZ / (`DSPR_OS_RATE * `DSPR_BAUD_BASE * 8));
      3'd4:    baud_div = 11'(`DSPR_SYS_CLK_HZ / (`DSPR_OS_RATE * `DSPR_BAUD_BASE * 16));
      default: baud_div = 11'(`DSPR_SYS_CLK_HZ / (`DSPR_OS_RATE * `DSPR_BAUD_BASE * 32));
    endcase
  endfunction

  function automatic logic par_on(input logic [1:0] p);
    par_on = (p == `DSPR_PAR_ODD) || (p == `DSPR_PAR_EVEN);
  endfunction

  function automatic logic par_bit(input logic [7:0] d, input logic [1:0] p);
    par_bit = (^d) ^ (p == `DSPR_PAR_ODD);
  endfunction

  logic        rx_s1_q, rx_s2_q, tx_q, hready_q, hresp_q, wr_pend_q;
  logic [31:0] hrdata_q, rdata, rec_cnt_q;
  logic [15:0] ctrl_q;
  logic [7:0]  a_q, rx_sh_q, rx_byte, tx_sh_q;
  logic [10:0] div_cnt_q, act_div;
  logic [7:0]  act_addr;
  logic [1:0]  act_par;
  logic        act_data8, tick_q;
  dspr_mode_t  mode_q;
  dspr_rx_t    rx_st_q;
  dspr_tx_t    tx_st_q;
  logic [3:0]  rx_os_q, tx_os_q;
  logic [2:0]  rx_bit_q, tx_bit_q;
  logic [5:0]  gap_q;
  logic        head_q, rx_pbit_q, rx_ferr_q, rx_done_q, tx_par_q, tx_line;
  logic        perr, good, match, keep_ev, addressed_q;
  logic        perr_q, ferr_q, ovr_q;
  logic        accept, wr_go, st_clr;
  logic        rx_in_valid, rx_in_ready, rx_out_valid, rx_out_ready;
  logic        tx_in_valid, tx_in_ready, tx_out_valid, tx_out_ready;
  logic [7:0]  rx_out_data, tx_out_data;

  assign hreadyout = hready_q;
  assign hresp     = hresp_q;
  assign hrdata    = hrdata_q;
  assign ser_tx    = tx_q;

  always_comb
  begin
    if (mode_q != DSPR_M_NORMAL)
    begin
      act_div   = baud_div(`DSPR_BAUD_9600);
      act_data8 = 1'b1;
      act_par   = `DSPR_PAR_NONE;
      act_addr  = `DSPR_REC_ADDR;
    end
    else
    begin
      act_div   = baud_div(ctrl_q[`DSPR_CTRL_BAUD]);
      act_data8 = ctrl_q[`DSPR_CTRL_DATA8];
      act_par   = ctrl_q[`DSPR_CTRL_PAR];
      act_addr  = ctrl_q[`DSPR_CTRL_ADDR];
    end
  end

  // 16x oversampling enable, shared by both directions
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      div_cnt_q <= '0;
      tick_q    <= 1'b0;
    end
    else if (div_cnt_q >= act_div - 11'd1)
    begin
      div_cnt_q <= '0;
      tick_q    <= 1'b1;
    end
    else
    begin
      div_cnt_q <= div_cnt_q + 11'd1;
      tick_q    <= 1'b0;
    end
  end

  // receive line is its own pin, synchronised
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rx_s1_q <= 1'b1;
      rx_s2_q <= 1'b1;
    end
    else
    begin
      rx_s1_q <= ser_rx;
      rx_s2_q <= rx_s1_q;
    end
  end

  // receive framing; idle gap marks the address byte of a message
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rx_st_q   <= DSPR_RX_IDLE;
      rx_os_q   <= '0;
      rx_bit_q  <= '0;
      rx_sh_q   <= '0;
      gap_q     <= `DSPR_GAP_BITS;
      head_q    <= 1'b0;
      rx_pbit_q <= 1'b0;
      rx_ferr_q <= 1'b0;
      rx_done_q <= 1'b0;
    end
    else
    begin
      rx_done_q <= 1'b0;
      if (tick_q)
      begin
        rx_os_q <= rx_os_q + 4'd1;
        case (rx_st_q)
          DSPR_RX_IDLE:
          begin
            if (rx_os_q == 4'd15 && gap_q < `DSPR_GAP_BITS)
              gap_q <= gap_q + 6'd1;
            if (!rx_s2_q)
            begin
              rx_st_q <= DSPR_RX_START;
              rx_os_q <= '0;
              head_q  <= (gap_q >= `DSPR_GAP_BITS);
              gap_q   <= '0;
            end
          end
          DSPR_RX_START:
            if (rx_os_q == 4'd7)
            begin
              rx_os_q  <= '0;
              rx_bit_q <= '0;
              rx_st_q  <= rx_s2_q ? DSPR_RX_IDLE : DSPR_RX_DATA;
            end
          DSPR_RX_DATA:
            if (rx_os_q == 4'd15)
            begin
              rx_sh_q  <= {rx_s2_q, rx_sh_q[7:1]};
              rx_bit_q <= rx_bit_q + 3'd1;
              if (rx_bit_q == (act_data8 ? 3'd7 : 3'd6))
                rx_st_q <= par_on(act_par) ? DSPR_RX_PAR : DSPR_RX_STOP;
            end
          DSPR_RX_PAR:
            if (rx_os_q == 4'd15)
            begin
              rx_pbit_q <= rx_s2_q;
              rx_st_q   <= DSPR_RX_STOP;
            end
          DSPR_RX_STOP:
            if (rx_os_q == 4'd15)
            begin
              rx_done_q <= 1'b1;
              rx_ferr_q <= !rx_s2_q;
              rx_st_q   <= DSPR_RX_IDLE;
            end
          default: rx_st_q <= DSPR_RX_IDLE;
        endcase
      end
    end
  end

  assign rx_byte = act_data8 ? rx_sh_q : {1'b0, rx_sh_q[7:1]};
  assign perr    = par_on(act_par) && (rx_pbit_q != par_bit(rx_byte, act_par));
  assign good    = rx_done_q && !perr && !rx_ferr_q;
  assign match   = (rx_byte == act_addr);
  assign keep_ev = (mode_q == DSPR_M_WAIT) && good && head_q && match;

  // address filter gating replies and received data
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      addressed_q <= 1'b0;
    else if (good && head_q)
      addressed_q <= match;
  end
  assign rx_in_valid = good && (head_q ? match : addressed_q);

  // window counter runs only while unresolved
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      rec_cnt_q <= '0;
    else if (mode_q == DSPR_M_WAIT)
      rec_cnt_q <= rec_cnt_q + 32'd1;
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      mode_q <= DSPR_M_WAIT;
    else
      case (mode_q)
        DSPR_M_WAIT:
          // message in window keeps recovery setup
          if (keep_ev)
            mode_q <= DSPR_M_KEEP;
          else if (rec_cnt_q == 32'(REC_CYCLES - 1))
            mode_q <= DSPR_M_NORMAL;
        DSPR_M_KEEP:   mode_q <= DSPR_M_KEEP;
        DSPR_M_NORMAL: mode_q <= DSPR_M_NORMAL;
        default:       mode_q <= DSPR_M_WAIT;
      endcase
  end

  // sticky errors; a new event wins over a write-one clear
  assign st_clr = wr_go && (a_q == `DSPR_OFF_STATUS);
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      perr_q <= 1'b0;
      ferr_q <= 1'b0;
      ovr_q  <= 1'b0;
    end
    else
    begin
      perr_q <= (rx_done_q && perr) || (perr_q && !(st_clr && hwdata[`DSPR_ST_PERR]));
      ferr_q <= (rx_done_q && rx_ferr_q) || (ferr_q && !(st_clr && hwdata[`DSPR_ST_FERR]));
      ovr_q  <= (rx_in_valid && !rx_in_ready) || (ovr_q && !(st_clr && hwdata[`DSPR_ST_OVR]));
    end
  end

  // rx cannot be stalled by the line, so a full queue drops and flags overrun
  dspr_fifo #(.W(8), .D(FIFO_DEPTH)) u_rx_fifo (
    .clk       (sys_clk),
    .rst_n     (rst_n),
    .in_valid  (rx_in_valid),
    .in_ready  (rx_in_ready),
    .in_data   (rx_byte),
    .out_valid (rx_out_valid),
    .out_ready (rx_out_ready),
    .out_data  (rx_out_data)
  );

  // full tx queue stalls the bus write through hreadyout
  dspr_fifo #(.W(8), .D(FIFO_DEPTH)) u_tx_fifo (
    .clk       (sys_clk),
    .rst_n     (rst_n),
    .in_valid  (tx_in_valid),
    .in_ready  (tx_in_ready),
    .in_data   (hwdata[7:0]),
    .out_valid (tx_out_valid),
    .out_ready (tx_out_ready),
    .out_data  (tx_out_data)
  );

  assign tx_out_ready = (tx_st_q == DSPR_TX_IDLE) && tick_q && addressed_q;

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tx_st_q  <= DSPR_TX_IDLE;
      tx_os_q  <= '0;
      tx_bit_q <= '0;
      tx_sh_q  <= '0;
      tx_par_q <= 1'b0;
    end
    else if (tick_q)
    begin
      tx_os_q <= tx_os_q + 4'd1;
      case (tx_st_q)
        DSPR_TX_IDLE:
          if (tx_out_valid && addressed_q)
          begin
            tx_sh_q  <= act_data8 ? tx_out_data : {1'b0, tx_out_data[6:0]};
            tx_par_q <= par_bit(act_data8 ? tx_out_data : {1'b0, tx_out_data[6:0]}, act_par);
            tx_os_q  <= '0;
            tx_bit_q <= '0;
            tx_st_q  <= DSPR_TX_START;
          end
        DSPR_TX_START:
          if (tx_os_q == 4'd15)
            tx_st_q <= DSPR_TX_DATA;
        DSPR_TX_DATA:
          if (tx_os_q == 4'd15)
          begin
            tx_sh_q  <= {1'b0, tx_sh_q[7:1]};
            tx_bit_q <= tx_bit_q + 3'd1;
            if (tx_bit_q == (act_data8 ? 3'd7 : 3'd6))
              tx_st_q <= par_on(act_par) ? DSPR_TX_PAR : DSPR_TX_STOP;
          end
        DSPR_TX_PAR:
          if (tx_os_q == 4'd15)
            tx_st_q <= DSPR_TX_STOP;
        DSPR_TX_STOP:
          if (tx_os_q == 4'd15)
            tx_st_q <= DSPR_TX_IDLE;
        default: tx_st_q <= DSPR_TX_IDLE;
      endcase
    end
  end

  always_comb
  begin
    case (tx_st_q)
      DSPR_TX_START: tx_line = 1'b0;
      DSPR_TX_DATA:  tx_line = tx_sh_q[0];
      DSPR_TX_PAR:   tx_line = tx_par_q;
      default:       tx_line = 1'b1;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      tx_q <= 1'b1;
    else
      tx_q <= tx_line;
  end

  // ahb-lite slave: reads zero wait, writes one wait plus tx back-pressure
  assign accept       = hsel && htrans[1] && hready;
  assign wr_go        = wr_pend_q && ((a_q != `DSPR_OFF_TXDATA) || tx_in_ready);
  assign tx_in_valid  = wr_pend_q && (a_q == `DSPR_OFF_TXDATA);
  assign rx_out_ready = accept && !hwrite && (haddr[7:0] == `DSPR_OFF_RXDATA);

  always_comb
  begin
    rdata = '0;
    case (haddr[7:0])
      `DSPR_OFF_CTRL:   rdata[15:0] = ctrl_q;
      `DSPR_OFF_STATUS: rdata[8:0]  = {tx_st_q != DSPR_TX_IDLE, !tx_in_ready, rx_out_valid,
                                       ovr_q, ferr_q, perr_q, addressed_q, mode_q};
      `DSPR_OFF_RXDATA: rdata[8:0]  = {rx_out_valid, rx_out_data};
      default:          rdata       = '0;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      hready_q  <= 1'b1;
      hresp_q   <= 1'b0;
      hrdata_q  <= '0;
      wr_pend_q <= 1'b0;
      a_q       <= '0;
    end
    else
    begin
      hresp_q <= 1'b0;
      if (accept && !hwrite)
        hrdata_q <= rdata;
      if (accept && hwrite)
      begin
        wr_pend_q <= 1'b1;
        hready_q  <= 1'b0;
        a_q       <= haddr[7:0];
      end
      else if (wr_go)
      begin
        wr_pend_q <= 1'b0;
        hready_q  <= 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      ctrl_q <= `DSPR_CTRL_RST;
    else if (wr_go && a_q == `DSPR_OFF_CTRL)
      ctrl_q <= hwdata[15:0];
  end

  // shadow of the character on the line, so the parity check does not reuse tx_par_q
  logic [7:0] tx_chr_q;
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      tx_chr_q <= '0;
    else if (tx_out_ready && tx_out_valid)
      tx_chr_q <= tx_out_data;
  end

  default clocking dspr_cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  chk_rec_setup: assert property (mode_q != DSPR_M_NORMAL |->
    act_addr == 8'hfe && act_div == 11'd130 && act_data8 && act_par == 2'd0)
    else $error("recovery setup not in force");
  chk_keep_sticks: assert property (mode_q == DSPR_M_KEEP |=> mode_q == DSPR_M_KEEP)
    else $error("recovery setup lost");
  chk_msg_keeps: assert property (keep_ev |=> mode_q == DSPR_M_KEEP)
    else $error("message in window ignored");
  chk_win_expire: assert property ((mode_q == DSPR_M_WAIT && !keep_ev &&
    rec_cnt_q == 32'(REC_CYCLES - 1)) |=> mode_q == DSPR_M_NORMAL)
    else $error("window did not expire");
  chk_cnt_frozen: assert property (mode_q != DSPR_M_WAIT |=> $stable(rec_cnt_q))
    else $error("window counter moved after resolve");
  chk_reset_cfg: assert property ($rose(rst_n) |-> ctrl_q == 16'h000d)
    else $error("control reset value wrong");
  chk_tx_gate: assert property ((tx_st_q == DSPR_TX_IDLE && !addressed_q)
    |=> tx_st_q == DSPR_TX_IDLE) else $error("reply without address match");
  chk_start_low: assert property (tx_st_q == DSPR_TX_START |=> ser_tx == 1'b0)
    else $error("start bit not low");
  chk_stop_high: assert property (tx_st_q == DSPR_TX_STOP |=> ser_tx == 1'b1)
    else $error("stop bit not high");
  chk_par_out: assert property (tx_st_q == DSPR_TX_PAR |=>
    ser_tx == ((^(act_data8 ? tx_chr_q : {1'b0, tx_chr_q[6:0]})) ^ (act_par == `DSPR_PAR_ODD)))
    else $error("parity bit wrong");
  chk_seven_bits: assert property ((tick_q && rx_st_q == DSPR_RX_DATA && !act_data8 &&
    rx_os_q == 4'd15 && rx_bit_q == 3'd6) |=> rx_st_q != DSPR_RX_DATA)
    else $error("seven-bit frame too long");

  cov_keep:   cover property (mode_q == DSPR_M_WAIT ##1 mode_q == DSPR_M_KEEP);
  cov_normal: cover property (mode_q == DSPR_M_WAIT ##1 mode_q == DSPR_M_NORMAL);
  cov_reply:  cover property (tx_st_q == DSPR_TX_IDLE ##1 tx_st_q == DSPR_TX_START);
  cov_stall:  cover property (wr_pend_q && !tx_in_ready);
endmodule

// file: verification/dspr_host_model.sv
`timescale 1ns/1ps
module dspr_host_model
(
  input  wire logic clk,      // bench clock for bit timing
  output logic      line_out, // host-to-drive line
  input  wire logic line_in   // drive-to-host line
);
  int         bit_cyc = 512;
  int         nbits   = 8;
  int         par     = 0;
  int         errs    = 0;
  logic [7:0] rx_q[$];

  initial line_out = 1'b1;

  task automatic wait_bits(input int n);
    repeat (n * bit_cyc) @(posedge clk);
  endtask

  task automatic send(input logic [7:0] c, input logic bad);
    logic [7:0] d;
    d = (nbits == 7) ? (c & 8'h7f) : c;
    line_out <= 1'b0;
    wait_bits(1);
    for (int i = 0; i < nbits; i++)
    begin
      line_out <= d[i];
      wait_bits(1);
    end
    if (par != 0)
    begin
      // flipping the bit on demand lets the bench provoke a refused character
      line_out <= ^d ^ (par == 1) ^ bad;
      wait_bits(1);
    end
    line_out <= 1'b1;
    wait_bits(1);
  endtask

  initial
  begin
    logic [7:0] d;
    logic       p;
    forever
    begin
      @(negedge line_in);
      repeat (bit_cyc / 2) @(posedge clk);
      if (line_in === 1'b0)
      begin
        d = 8'h00;
        for (int i = 0; i < nbits; i++)
        begin
          repeat (bit_cyc) @(posedge clk);
          d[i] = line_in;
        end
        p = ^d ^ (par == 1);
        if (par != 0)
        begin
          repeat (bit_cyc) @(posedge clk);
          if (line_in !== p)
            errs++;
        end
        repeat (bit_cyc) @(posedge clk);
        if (line_in !== 1'b1)
          errs++;
        rx_q.push_back(d);
      end
    end
  end
endmodule

// file: verification/test_drive_serial_port_with_recovery.sv
`timescale 1ns/1ps
`include "dspr_regs.svh"
module test_drive_serial_port_with_recovery;
  // window must outlast one frame at the recovery rate sent right after reset
  localparam int unsigned REC = 21000;
  logic        sys_clk;
  logic        rst_n;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic        hwrite;
  logic [31:0] hwdata;
  logic        hready;
  logic        hresp;
  logic [31:0] hrdata;
  logic        ser_rx;
  logic        ser_tx;
  logic [31:0] rd;
  int          err_total;
  int          samples_checked;
  int unsigned cyc;

  dspr_serial_port #(.REC_CYCLES(REC), .FIFO_DEPTH(32)) DUT
  (
    .sys_clk   (sys_clk),
    .rst_n     (rst_n),
    .hsel      (hsel),
    .haddr     (haddr),
    .htrans    (htrans),
    .hwrite    (hwrite),
    .hsize     (hsize),
    .hwdata    (hwdata),
    .hready    (hready),
    .hreadyout (hready),
    .hresp     (hresp),
    .hrdata    (hrdata),
    .ser_rx    (ser_rx),
    .ser_tx    (ser_tx)
  );

  dspr_host_model host (.clk(sys_clk), .line_out(ser_rx), .line_in(ser_tx));

  initial
  begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk or negedge rst_n)
    if (!rst_n)
      cyc <= 0;
    else
      cyc <= cyc + 1;

  task automatic stop_test();
    if (err_total == 0 && samples_checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic check(input string n, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e)
    begin
      err_total++;
      $display("unexpected %s: expected %h seen %h", n, e, g);
    end
  endtask

  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel   <= 1'b1;
    haddr  <= {24'h0, a};
    htrans <= 2'b10;
    hsize  <= 3'b010;
    hwrite <= w;
    @(posedge sys_clk);
    while (hready !== 1'b1) @(posedge sys_clk);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hsize  <= 3'b000;
    hwdata <= d;
    @(posedge sys_clk);
    while (hready !== 1'b1) @(posedge sys_clk);
    rd = hrdata;
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
                      input string n);
    ahb(1'b0, a, 32'h0);
    check(n, e, rd & m);
    check("hresp", 32'h0, {31'h0, hresp});
  endtask

  task automatic wait_rx(input logic [7:0] e);
    int          k;
    logic [31:0] g;
    k = 0;
    while (host.rx_q.size() == 0 && k < 30000)
    begin
      @(posedge sys_clk);
      k++;
    end
    if (host.rx_q.size() == 0)
      g = 32'hffff_ffff;
    else
      g = {24'h0, host.rx_q.pop_front()};
    check("host rx char", {24'h0, e}, g);
  endtask

  task automatic do_reset();
    @(posedge sys_clk);
    rst_n <= 1'b0;
    repeat (4) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
  endtask

  task automatic t_reset_state();
    rchk(`DSPR_OFF_CTRL, 32'hffff, 32'h000d, "ctrl reset");
    rchk(`DSPR_OFF_STATUS, 32'h3, 32'h0, "mode in window");
    ahb(1'b1, 8'h10, 32'hffff_ffff);
    rchk(8'h10, 32'hffff_ffff, 32'h0, "unmapped read");
  endtask

  task automatic t_window_expiry();
    while (cyc < REC - 100) @(posedge sys_clk);
    rchk(`DSPR_OFF_STATUS, 32'h3, 32'h0, "mode before expiry");
    while (cyc < REC + 100) @(posedge sys_clk);
    rchk(`DSPR_OFF_STATUS, 32'h3, 32'h2, "mode after expiry");
  endtask

  task automatic t_addressing();
    // line has idled through the whole window, so this byte already heads a message
    host.send(8'h07, 1'b0);
    host.send(8'h11, 1'b0);
    host.wait_bits(1);
    rchk(`DSPR_OFF_STATUS, 32'h4, 32'h0, "addressed flag");
    rchk(`DSPR_OFF_RXDATA, 32'h100, 32'h0, "foreign rx valid");
    ahb(1'b1, `DSPR_OFF_TXDATA, 32'ha5);
    // long enough for a wrong reply to land and for the idle gap of the next message
    host.wait_bits(20);
    check("chars while unaddressed", 32'h0, host.rx_q.size());
    host.send(8'h00, 1'b0);
    host.send(8'h5a, 1'b0);
    host.wait_bits(1);
    rchk(`DSPR_OFF_RXDATA, 32'h1ff, 32'h100, "rx address byte");
    rchk(`DSPR_OFF_RXDATA, 32'h1ff, 32'h15a, "rx data byte");
    wait_rx(8'ha5);
  endtask

  task automatic t_framing();
    // 38400 baud, seven bits, even parity, address 0
    ahb(1'b1, `DSPR_OFF_CTRL, 32'h0000_0025);
    host.nbits = 7;
    host.par   = 2;
    host.wait_bits(2);
    host.send(8'h3c, 1'b0);
    host.wait_bits(1);
    rchk(`DSPR_OFF_RXDATA, 32'h1ff, 32'h13c, "rx seven bit char");
    host.send(8'h3c, 1'b1);
    host.wait_bits(1);
    rchk(`DSPR_OFF_STATUS, 32'h8, 32'h8, "parity error flag");
    rchk(`DSPR_OFF_RXDATA, 32'h100, 32'h0, "bad char dropped");
    ahb(1'b1, `DSPR_OFF_TXDATA, 32'hc3);
    wait_rx(8'h43);
    check("tx parity faults", 32'h0, host.errs);
  endtask

  task automatic t_recovery();
    do_reset();
    host.bit_cyc = 2080;
    host.nbits   = 8;
    host.par     = 0;
    // idle gap counts as met after reset, so the message goes out at once
    host.send(8'hfe, 1'b0);
    repeat (200) @(posedge sys_clk);
    rchk(`DSPR_OFF_STATUS, 32'h3, 32'h1, "mode kept");
    rchk(`DSPR_OFF_RXDATA, 32'h1ff, 32'h1fe, "recovery address");
    ahb(1'b1, `DSPR_OFF_TXDATA, 32'h96);
    wait_rx(8'h96);
    while (cyc < REC + 100) @(posedge sys_clk);
    rchk(`DSPR_OFF_STATUS, 32'h3, 32'h1, "mode after window");
  endtask

  initial
  begin
    err_total       = 0;
    samples_checked = 0;
    rst_n           = 1'b0;
    hsel            = 1'b0;
    haddr           = 32'h0;
    htrans          = 2'b00;
    hsize           = 3'b000;
    hwrite          = 1'b0;
    hwdata          = 32'h0;
    do_reset();
    t_reset_state();
    t_window_expiry();
    t_addressing();
    t_framing();
    t_recovery();
    stop_test();
  end

  // the full sequence needs about 110k cycles; leave some slack
  initial
  begin
    repeat (140000) @(posedge sys_clk);
    err_total++;
    stop_test();
  end
endmodule
